// ### io_exp_cfg_map.vh
/*
 Offsets, field positions, reset values and timing figures for the
 configuration register group of the GPIO expander.
 Assumes inclusion by io_expander_misc_config.v only.
*/
`ifndef IO_EXP_CFG_MAP_VH
`define IO_EXP_CFG_MAP_VH

`define OFS_LS_UPPER 8'h1C
`define OFS_LS_LOWER 8'h1D
`define OFS_CLK_CTRL 8'h1E
`define OFS_MISC 8'h1F
`define OFS_LED_EN_B 8'h20
`define OFS_LED_EN_A 8'h21
`define OFS_DEB_TIME 8'h22
`define OFS_DEB_EN_B 8'h23
`define OFS_DEB_EN_A 8'h24

`define RST_CFG 8'h00
`define RST_DEB_TIME 8'h00

`define LS_OFF 2'h0
`define LS_A_TO_B 2'h1
`define LS_B_TO_A 2'h2

`define SRC_OFF 2'h0
`define SRC_EXT 2'h1
`define SRC_INT 2'h2
`define CLK_SRC_HI 6
`define CLK_SRC_LO 5
`define CLK_PIN_DIR 4
`define CLK_DIV_HI 3
`define CLK_DIV_LO 0
`define DIV_LOW 4'h0
`define DIV_HIGH 4'hF

`define MISC_LOG_B 7
`define MISC_LED_HI 6
`define MISC_LED_LO 4
`define MISC_LOG_A 3
`define MISC_RST_FN 2
`define MISC_FIXED_ADDR 1
`define MISC_NO_AUTOCLR 0

`define DEB_BASE_US 500
`define OSC_REF_KHZ 2000
`define DEB_MAX_CODE 3'h6

`endif

// ### io_expander_misc_config.v
/*
 Configuration register group of a GPIO expander: level shift modes,
 oscillator source and divided pin output, LED clock divider and laws,
 reset-pin function, address increment, interrupt autoclear, LED and
 debounce enables, debounce time.
 Assumes the bus slave gives byte strobes on clk, the oscillator core
 gives one pulse per oscillator edge, and the pin and edge blocks
 sit outside.
*/
`timescale 1ns/10ps
`default_nettype none
`include "io_exp_cfg_map.vh"

module io_expander_misc_config #(
    parameter DIV_W = 14
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output wire addr_auto_inc,
    // Oscillator
    input wire int_osc_edge,
    input wire shared_osc_pin_in,
    output reg shared_osc_pin_out,
    output wire shared_osc_pin_oe,
    output wire osc_enable,
    output wire osc_edge,
    output wire led_engine_edge,
    // Level shifting per pair, indexed by bank A pin
    output reg [7:0] shift_a_to_b,
    output reg [7:0] shift_b_to_a,
    // LED driver
    output wire [15:0] led_drive_en,
    output wire log_mode_bank_a,
    output wire log_mode_bank_b,
    // Debounce
    output wire [15:0] debounce_en,
    output reg [15:0] debounce_periods,
    // Reset pin
    input wire ext_reset_pin_n,
    output reg full_reset_req,
    output reg counter_restart,
    // Interrupts
    input wire data_read_a,
    input wire data_read_b,
    input wire [7:0] irq_source_a,
    input wire [7:0] irq_source_b,
    output reg irq_clear_a,
    output reg irq_clear_b,
    output wire irq_out_n_out,
    output reg irq_out_n_oe
);

reg [7:0] ls_upper;
reg [7:0] ls_lower;
reg [7:0] clk_ctrl;
reg [7:0] misc;
reg [7:0] led_en_b;
reg [7:0] led_en_a;
reg [7:0] deb_time;
reg [7:0] deb_en_b;
reg [7:0] deb_en_a;
reg [2:0] osc_sync;
reg osc_level;
reg [2:0] rst_sync;
reg rst_level;
reg [DIV_W-1:0] div_cnt;
reg [DIV_W-1:0] led_mask;
reg [15:0] next_deb;
reg [3:0] div_sel;
reg src_on;
reg src_edge;
reg [31:0] deb_wide;
wire [15:0] mode_pairs;
wire [1:0] src;
wire pin_is_out;
wire ext_edge;
wire [2:0] led_sel;
wire led_on;
wire rst_fall;

localparam [31:0] DEB_BASE = `DEB_BASE_US * `OSC_REF_KHZ / 1000;

assign mode_pairs = {ls_upper, ls_lower};

// Pair i sits in bits 2i+1:2i of the combined field
genvar i;
generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_pair
        always @(posedge clk or posedge rst)
        begin
            if (rst)
            begin
                shift_a_to_b[i] <= 1'b0;
                shift_b_to_a[i] <= 1'b0;
            end
            else
            begin
                // Reserved code drives neither way
                shift_a_to_b[i] <= mode_pairs[2*i+1:2*i] == `LS_A_TO_B;
                shift_b_to_a[i] <= mode_pairs[2*i+1:2*i] == `LS_B_TO_A;
            end
        end
    end
endgenerate

// Oscillator pin and clock source
assign src = clk_ctrl[`CLK_SRC_HI:`CLK_SRC_LO];
assign pin_is_out = clk_ctrl[`CLK_PIN_DIR];
assign shared_osc_pin_oe = pin_is_out;

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        osc_sync <= 3'h0;
        osc_level <= 1'b0;
        rst_sync <= 3'h7;
        rst_level <= 1'b1;
    end
    else
    begin
        osc_sync <= {osc_sync[1:0], shared_osc_pin_in};
        rst_sync <= {rst_sync[1:0], ext_reset_pin_n};
        if (osc_sync[1] == osc_sync[2])
            osc_level <= osc_sync[2];
        if (rst_sync[1] == rst_sync[2])
            rst_level <= rst_sync[2];
    end
end

// External clock only exists while the pin is an input
assign ext_edge = !pin_is_out && (osc_sync[1] == osc_sync[2]) &&
    (osc_sync[2] != osc_level);

always @*
begin
    src_on = 1'b0;
    src_edge = 1'b0;
    case (src)
        `SRC_EXT:
        begin
            src_on = 1'b1;
            src_edge = ext_edge;
        end
        `SRC_INT:
        begin
            src_on = 1'b1;
            src_edge = int_osc_edge;
        end
        // Off and the reserved code leave every engine unclocked
        default:
        begin
            src_on = 1'b0;
            src_edge = 1'b0;
        end
    endcase
end

assign osc_enable = src_on;
assign osc_edge = src_edge;

// One count per oscillator edge, so bit k runs at osc_frequency/2^k
always @(posedge clk or posedge rst)
begin
    if (rst)
        div_cnt <= {DIV_W{1'b0}};
    else if (!osc_enable)
        div_cnt <= {DIV_W{1'b0}};
    else if (osc_edge)
        div_cnt <= div_cnt + 1'b1;
end

always @*
begin
    div_sel = clk_ctrl[`CLK_DIV_HI:`CLK_DIV_LO] - 4'h1;
end

always @(posedge clk or posedge rst)
begin
    if (rst)
        shared_osc_pin_out <= 1'b0;
    else if (clk_ctrl[`CLK_DIV_HI:`CLK_DIV_LO] == `DIV_LOW)
        shared_osc_pin_out <= 1'b0;
    else if (clk_ctrl[`CLK_DIV_HI:`CLK_DIV_LO] == `DIV_HIGH)
        shared_osc_pin_out <= 1'b1;
    else if (div_sel < DIV_W)
        shared_osc_pin_out <= div_cnt[div_sel];
    else
        shared_osc_pin_out <= 1'b0;
end

// LED clock
assign led_sel = misc[`MISC_LED_HI:`MISC_LED_LO];
assign led_on = (led_sel != 3'h0) && osc_enable;

always @*
begin
    led_mask = {DIV_W{1'b0}};
    if (led_sel > 3'h1)
        led_mask = ({{(DIV_W-1){1'b0}}, 1'b1} << (led_sel - 3'h1)) -
            {{(DIV_W-1){1'b0}}, 1'b1};
end

// Edge of the divided clock: all lower counter bits set
assign led_engine_edge = led_on && osc_edge &&
    ((div_cnt & led_mask) == led_mask);
assign led_drive_en = {led_en_b, led_en_a} & {16{led_on}};
assign log_mode_bank_b = misc[`MISC_LOG_B];
assign log_mode_bank_a = misc[`MISC_LOG_A];

// Debounce
assign debounce_en = {deb_en_b, deb_en_a} & {16{osc_enable}};

always @*
begin
    next_deb = 16'h0000;
    // Undefined top code saturates at the longest time
    deb_wide = 32'h00000000;
    if (deb_time[2:0] > `DEB_MAX_CODE)
        deb_wide = DEB_BASE << `DEB_MAX_CODE;
    else
        deb_wide = DEB_BASE << deb_time[2:0];
    // Longest time still fits 16 bits, so the cut loses nothing
    next_deb = deb_wide[15:0];
end

always @(posedge clk or posedge rst)
begin
    if (rst)
        debounce_periods <= 16'h0000;
    else
        debounce_periods <= next_deb;
end

// Reset pin and interrupt glue
assign rst_fall = rst_level && (rst_sync[1] == rst_sync[2]) &&
    !rst_sync[2];
assign addr_auto_inc = !misc[`MISC_FIXED_ADDR];
assign irq_out_n_out = 1'b0;

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        full_reset_req <= 1'b0;
        counter_restart <= 1'b0;
        irq_clear_a <= 1'b0;
        irq_clear_b <= 1'b0;
        irq_out_n_oe <= 1'b0;
    end
    else
    begin
        full_reset_req <= rst_fall && !misc[`MISC_RST_FN];
        counter_restart <= rst_fall && misc[`MISC_RST_FN];
        irq_clear_a <= data_read_a && !misc[`MISC_NO_AUTOCLR];
        irq_clear_b <= data_read_b && !misc[`MISC_NO_AUTOCLR];
        irq_out_n_oe <= |{irq_source_a, irq_source_b};
    end
end

// Register file; a full reset from the pin clears it like power-on
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        ls_upper <= `RST_CFG;
        ls_lower <= `RST_CFG;
        clk_ctrl <= `RST_CFG;
        misc <= `RST_CFG;
        led_en_b <= `RST_CFG;
        led_en_a <= `RST_CFG;
        deb_time <= `RST_DEB_TIME;
        deb_en_b <= `RST_CFG;
        deb_en_a <= `RST_CFG;
    end
    else if (rst_fall && !misc[`MISC_RST_FN])
    begin
        ls_upper <= `RST_CFG;
        ls_lower <= `RST_CFG;
        clk_ctrl <= `RST_CFG;
        misc <= `RST_CFG;
        led_en_b <= `RST_CFG;
        led_en_a <= `RST_CFG;
        deb_time <= `RST_DEB_TIME;
        deb_en_b <= `RST_CFG;
        deb_en_a <= `RST_CFG;
    end
    else if (reg_wr)
    begin
        case (reg_addr)
            `OFS_LS_UPPER: ls_upper <= reg_wdata;
            `OFS_LS_LOWER: ls_lower <= reg_wdata;
            `OFS_CLK_CTRL: clk_ctrl <= {1'b0, reg_wdata[6:0]};
            `OFS_MISC: misc <= reg_wdata;
            `OFS_LED_EN_B: led_en_b <= reg_wdata;
            `OFS_LED_EN_A: led_en_a <= reg_wdata;
            `OFS_DEB_TIME: deb_time <= {5'h00, reg_wdata[2:0]};
            `OFS_DEB_EN_B: deb_en_b <= reg_wdata;
            `OFS_DEB_EN_A: deb_en_a <= reg_wdata;
            default: ;
        endcase
    end
end

always @(posedge clk or posedge rst)
begin
    if (rst)
        reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
        case (reg_addr)
            `OFS_LS_UPPER: reg_rdata <= ls_upper;
            `OFS_LS_LOWER: reg_rdata <= ls_lower;
            `OFS_CLK_CTRL: reg_rdata <= clk_ctrl;
            `OFS_MISC: reg_rdata <= misc;
            `OFS_LED_EN_B: reg_rdata <= led_en_b;
            `OFS_LED_EN_A: reg_rdata <= led_en_a;
            `OFS_DEB_TIME: reg_rdata <= deb_time;
            `OFS_DEB_EN_B: reg_rdata <= deb_en_b;
            `OFS_DEB_EN_A: reg_rdata <= deb_en_a;
            default: reg_rdata <= 8'h00;
        endcase
    end
end

endmodule

`default_nettype wire

// ### io_exp_cfg_monitor.sv
/* Port checker for io_expander_misc_config.
   Bound from the bench top; sees design ports only. */
`timescale 1ns/10ps
`default_nettype none
module io_exp_cfg_monitor (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register port and oscillator pin enable
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire addr_auto_inc,
    input wire shared_osc_pin_oe,
    // Reset pin and interrupts
    input wire ext_reset_pin_n,
    input wire full_reset_req,
    input wire counter_restart,
    input wire data_read_a,
    input wire irq_clear_a,
    input wire [7:0] irq_source_a,
    input wire [7:0] irq_source_b,
    input wire irq_out_n_oe
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    a_pin_dir_follows: assert property (
        reg_wr && reg_addr == 8'h1E
        |=> shared_osc_pin_oe == $past(reg_wdata[4])) else $error("pin oe");
    a_addr_inc_follows: assert property (
        reg_wr && reg_addr == 8'h1F
        |=> addr_auto_inc != $past(reg_wdata[1])) else $error("addr inc");
    a_unmapped_zero: assert property (
        reg_rd && (reg_addr < 8'h1C || reg_addr > 8'h24)
        |=> reg_rdata == 8'h00) else $error("unmapped read");
    a_clear_needs_read: assert property (
        irq_clear_a |-> $past(data_read_a)) else $error("stray clear");
    a_irq_release: assert property (
        irq_source_a == 8'h00 && irq_source_b == 8'h00
        |=> !irq_out_n_oe) else $error("irq held");
    a_irq_pull_low: assert property (
        (|{irq_source_a, irq_source_b}) |=> irq_out_n_oe) else $error("irq");
    a_pin_pulse_cause: assert property (
        full_reset_req || counter_restart |-> !$past(ext_reset_pin_n, 3))
        else $error("pin pulse");
    a_pin_pulse_single: assert property (
        full_reset_req || counter_restart
        |=> !(full_reset_req || counter_restart)) else $error("long pulse");
    c_full: cover property (full_reset_req);
    c_restart: cover property (counter_restart);
    c_clear: cover property (irq_clear_a);
endmodule
`default_nettype wire

// ### host_model.sv
/* Host side of the byte register port.
   Assumes a free-running clk; strobes move at the falling edge. */
`timescale 1ns/10ps
`default_nettype none
module host_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic wr,
    output logic rd,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    initial {wr, rd, addr, wdata} = 18'h00000;
    // Idle lines show the inverse so stale values never look valid
    task automatic put(input logic [7:0] a, d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        addr = ~a;
        d = rdata;
    endtask
endmodule
`default_nettype wire

// ### tb_io_expander_misc_config.sv
/* Self-checking bench for io_expander_misc_config.
   Assumes host_model and io_exp_cfg_monitor compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb_io_expander_misc_config;
    logic clk = 0, rst = 1, int_osc_edge = 0, ext_reset_pin_n = 1;
    logic data_read_a = 0, data_read_b = 0, shared_osc_pin_in = 0, pq = 0;
    logic [7:0] irq_source_a = 8'h00, irq_source_b = 8'h00, r;
    wire reg_wr, reg_rd, addr_auto_inc, shared_osc_pin_out, irq_out_n_oe;
    wire shared_osc_pin_oe, osc_enable, osc_edge, led_engine_edge;
    wire log_mode_bank_a, log_mode_bank_b, full_reset_req, counter_restart;
    wire irq_clear_a, irq_clear_b, irq_out_n_out;
    wire [7:0] reg_addr, reg_wdata, reg_rdata, shift_a_to_b, shift_b_to_a;
    wire [15:0] led_drive_en, debounce_en, debounce_periods;
    int errors = 0, compares = 0, nl = 0, np = 0, nc = 0, nr = 0, a, b, c;

    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        nl <= nl + int'(led_engine_edge);
        np <= np + int'(shared_osc_pin_out !== pq);
        pq <= shared_osc_pin_out;
        nc <= nc + int'(irq_clear_a) + int'(irq_clear_b);
        nr <= nr + int'(counter_restart) + 4 * int'(full_reset_req);
    end

    host_model u_host (.clk, .wr(reg_wr), .rd(reg_rd), .addr(reg_addr),
        .wdata(reg_wdata), .rdata(reg_rdata));
    io_expander_misc_config u_dut (.clk, .rst, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .addr_auto_inc, .int_osc_edge,
        .shared_osc_pin_in, .shared_osc_pin_out, .shared_osc_pin_oe,
        .osc_enable, .osc_edge, .led_engine_edge, .shift_a_to_b,
        .shift_b_to_a, .led_drive_en, .log_mode_bank_a, .log_mode_bank_b,
        .debounce_en, .debounce_periods, .ext_reset_pin_n, .full_reset_req,
        .counter_restart, .data_read_a, .data_read_b, .irq_source_a,
        .irq_source_b, .irq_clear_a, .irq_clear_b, .irq_out_n_out,
        .irq_out_n_oe);

    task automatic chk(input logic [15:0] got, exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] ad, e);
        u_host.get(ad, r);
        chk({8'h00, r}, {8'h00, e});
    endtask
    task automatic pin_low;
        ext_reset_pin_n = 0;
        repeat (6) @(negedge clk);
        ext_reset_pin_n = 1;
        repeat (6) @(negedge clk);
    endtask
    task automatic print_verdict;
        if (errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(negedge clk);
        rst = 0;
        for (a = 8'h1C; a < 8'h25; a++)
            rchk(a[7:0], 8'h00);
        for (a = 8'h1C; a < 8'h25; a++)
        begin
            u_host.put(a[7:0], 8'hFF);
            rchk(a[7:0], a == 8'h1E ? 8'h7F : a == 8'h22 ? 8'h07 : 8'hFF);
            u_host.put(a[7:0], 8'h00);
        end
        u_host.put(8'h30, 8'hFF);
        rchk(8'h30, 8'h00);
        u_host.put(8'h1C, 8'hE4);
        u_host.put(8'h1D, 8'h63);
        repeat (2) @(negedge clk);
        chk({shift_b_to_a, shift_a_to_b}, 16'h4428);
        u_host.put(8'h20, 8'h3C);
        u_host.put(8'h21, 8'hC3);
        chk(led_drive_en, 16'h0000);
        u_host.put(8'h1F, 8'h98);
        chk(led_drive_en, 16'h0000);
        u_host.put(8'h1E, 8'h40);
        chk(led_drive_en, 16'h3CC3);
        chk({14'h0, log_mode_bank_b, log_mode_bank_a}, 16'h0003);
        u_host.put(8'h23, 8'h81);
        u_host.put(8'h24, 8'h18);
        u_host.put(8'h1E, 8'h60);
        chk(debounce_en, 16'h0000);
        chk({15'h0, osc_enable}, 16'h0000);
        u_host.put(8'h1E, 8'h20);
        chk(debounce_en, 16'h8118);
        for (c = 0; c < 8; c++)
        begin
            u_host.put(8'h22, c[7:0]);
            repeat (2) @(negedge clk);
            chk(debounce_periods, c == 7 ? 16'hFA00 : 16'h03E8 << c);
        end
        u_host.put(8'h1E, 8'h50);
        repeat (3) @(negedge clk);
        chk({14'h0, shared_osc_pin_oe, shared_osc_pin_out}, 16'h0002);
        u_host.put(8'h1E, 8'h5F);
        repeat (3) @(negedge clk);
        chk({15'h0, shared_osc_pin_out}, 16'h0001);
        for (c = 1; c < 4; c++)
        begin
            u_host.put(8'h1E, 8'h50 | c[7:0]);
            u_host.put(8'h1F, {1'b0, c[2:0], 4'h0});
            repeat (3) @(negedge clk);
            a = np;
            b = nl;
            repeat (8)
            begin
                int_osc_edge = 1;
                @(negedge clk);
                int_osc_edge = 0;
                @(negedge clk);
            end
            repeat (3) @(negedge clk);
            chk(16'(np - a), 16'(8 >> (c - 1)));
            chk(16'(nl - b), 16'(8 >> (c - 1)));
        end
        for (c = 0; c < 2; c++)
        begin
            u_host.put(8'h1E, c ? 8'h30 : 8'h20);
            u_host.put(8'h1F, 8'h10);
            b = nl;
            repeat (4)
            begin
                shared_osc_pin_in = ~shared_osc_pin_in;
                repeat (4) @(negedge clk);
            end
            repeat (3) @(negedge clk);
            chk(16'(nl - b), c ? 16'h0000 : 16'h0004);
        end
        u_host.put(8'h1C, 8'h44);
        u_host.put(8'h1F, 8'h04);
        a = nr;
        pin_low;
        chk(16'(nr - a), 16'h0001);
        rchk(8'h1F, 8'h04);
        rchk(8'h1C, 8'h44);
        u_host.put(8'h1F, 8'h00);
        a = nr;
        pin_low;
        chk(16'(nr - a), 16'h0004);
        rchk(8'h1C, 8'h00);
        u_host.put(8'h1F, 8'h02);
        chk({15'h0, addr_auto_inc}, 16'h0000);
        for (c = 0; c < 2; c++)
        begin
            u_host.put(8'h1F, c[7:0]);
            a = nc;
            data_read_a = 1;
            data_read_b = 1;
            @(negedge clk);
            data_read_a = 0;
            data_read_b = 0;
            repeat (3) @(negedge clk);
            chk(16'(nc - a), c ? 16'h0000 : 16'h0002);
        end
        chk({15'h0, addr_auto_inc}, 16'h0001);
        irq_source_a = 8'h80;
        repeat (2) @(negedge clk);
        chk({14'h0, irq_out_n_oe, irq_out_n_out}, 16'h0002);
        irq_source_a = 8'h00;
        repeat (2) @(negedge clk);
        chk({14'h0, irq_out_n_oe, irq_out_n_out}, 16'h0000);
        print_verdict;
    end
endmodule

bind io_expander_misc_config io_exp_cfg_monitor u_mon (.clk, .rst, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .addr_auto_inc,
    .shared_osc_pin_oe, .ext_reset_pin_n, .full_reset_req, .counter_restart,
    .data_read_a, .irq_clear_a, .irq_source_a, .irq_source_b, .irq_out_n_oe);
`default_nettype wire
